/* hw/drive_seq_pkg.sv */
// Constants and types shared by the drive power sequencer.
// Assumes a single 50 MHz clock; all times are counted from it.
package drive_seq_pkg;
  localparam int unsigned CLK_NS = 20;
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int unsigned TICK_W = 16;
  localparam int unsigned LOAD_DELAY_MS = 10000;
  localparam int unsigned BRAKE_MS = 30000;
  localparam int unsigned FLASH_MS = 250;
  localparam int unsigned TIME_W = 15;
  localparam int unsigned FLASH_W = 8;
  localparam int unsigned NUM_IN = 13;
  // Positions of the synchronised inputs in one vector
  localparam int unsigned IN_REMOTE = 0;
  localparam int unsigned IN_START = 1;
  localparam int unsigned IN_MAIN_BRK = 2;
  localparam int unsigned IN_AUX_BRK = 3;
  localparam int unsigned IN_DC_BRK = 4;
  localparam int unsigned IN_AUX_OK = 5;
  localparam int unsigned IN_PICK = 6;
  localparam int unsigned IN_HOLD = 7;
  localparam int unsigned IN_PACK = 8;
  localparam int unsigned IN_COVER = 9;
  localparam int unsigned IN_SPEED = 10;
  localparam int unsigned IN_LOADED = 11;
  localparam int unsigned IN_UNLOADED = 12;
  localparam logic [NUM_IN-1:0] IN_RESET = 13'h0000;
  typedef enum logic [2:0] {
    ST_IDLE, ST_SPINUP, ST_DELAY, ST_LOAD, ST_READY, ST_RTZ, ST_BRAKE
  } seq_state_t;
endpackage : drive_seq_pkg

/* hw/input_sync.sv */
// Three-stage synchroniser for switch and sensor levels.
// Assumes inputs are asynchronous to clk; output moves only when
// the second and third stages agree.
`timescale 1ns/100ps
`default_nettype none
module input_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Bits whose last two stages disagree keep their old value
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_out <= INIT;
    end else begin
      sync_out <= (stage2 & stage3) | (sync_out & (stage2 ^ stage3));
    end
  end
endmodule : input_sync
`default_nettype wire

/* hw/drive_power_sequencer.sv */
// Spindle and head power sequencer of one drive in a daisy chain.
// Assumes switch and sensor levels arrive asynchronously; relay
// drivers and chain outputs are registered on clk.
`timescale 1ns/100ps
`default_nettype none
module drive_power_sequencer #(
  parameter int unsigned TICK_CYCLES = drive_seq_pkg::TICK_CYCLES,
  parameter int unsigned LOAD_TICKS = drive_seq_pkg::LOAD_DELAY_MS,
  parameter int unsigned BRAKE_TICKS = drive_seq_pkg::BRAKE_MS,
  parameter int unsigned FLASH_TICKS = drive_seq_pkg::FLASH_MS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic remote_mode,
  input wire logic start_switch,
  input wire logic main_breaker,
  input wire logic aux_breaker,
  input wire logic dc_breakers_ok,
  input wire logic aux_supply_ok,
  input wire logic seq_pick_in,
  input wire logic seq_hold_in,
  input wire logic pack_present,
  input wire logic cover_closed,
  input wire logic speed_ok,
  input wire logic heads_loaded,
  input wire logic heads_unloaded,
  output logic seq_pick_out,
  output logic seq_hold_out,
  output logic sequence_power_ctl,
  output logic start_ctl,
  output logic start_lamp,
  output logic motor_power_ctl,
  output logic speed_ok_ctl,
  output logic retract_enable_ctl,
  output logic heads_load_go,
  output logic return_to_zero,
  output logic emergency_retract,
  output logic brake_power_ctl,
  output logic brake_apply_ctl,
  output logic ready_lamp,
  output logic cover_lock
);
  localparam int unsigned TW = drive_seq_pkg::TIME_W;
  localparam int unsigned KW = drive_seq_pkg::TICK_W;
  localparam int unsigned FW = drive_seq_pkg::FLASH_W;

  logic [drive_seq_pkg::NUM_IN-1:0] raw_in, in_s;
  logic remote_s, start_s, start_prev, start_press, speed_s;
  logic breakers_ok, interlocks_ok, chain_active, participating;
  logic drop_req, speed_lost, tick, flash;
  logic [KW-1:0] tick_cnt;
  logic [TW-1:0] time_cnt;
  logic [FW-1:0] flash_cnt;
  drive_seq_pkg::seq_state_t state, next_state;

  function automatic logic heads_flying(drive_seq_pkg::seq_state_t s);
    heads_flying = (s == drive_seq_pkg::ST_DELAY) ||
                   (s == drive_seq_pkg::ST_LOAD) ||
                   (s == drive_seq_pkg::ST_READY);
  endfunction : heads_flying
  function automatic logic spinning(drive_seq_pkg::seq_state_t s);
    spinning = heads_flying(s) || (s == drive_seq_pkg::ST_SPINUP);
  endfunction : spinning

  //////////////////////////////////////////////////////////////////////
  // Input synchronisation
  assign raw_in = {heads_unloaded, heads_loaded, speed_ok, cover_closed,
                   pack_present, seq_hold_in, seq_pick_in, aux_supply_ok,
                   dc_breakers_ok, aux_breaker, main_breaker, start_switch,
                   remote_mode};
  input_sync #(
    .WIDTH(drive_seq_pkg::NUM_IN),
    .INIT(drive_seq_pkg::IN_RESET)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(raw_in),
    .sync_out(in_s)
  );
  assign remote_s = in_s[drive_seq_pkg::IN_REMOTE];
  assign start_s = in_s[drive_seq_pkg::IN_START];
  assign speed_s = in_s[drive_seq_pkg::IN_SPEED];
  assign breakers_ok = in_s[drive_seq_pkg::IN_MAIN_BRK] &
                       in_s[drive_seq_pkg::IN_AUX_BRK] &
                       in_s[drive_seq_pkg::IN_DC_BRK];
  assign interlocks_ok = breakers_ok & in_s[drive_seq_pkg::IN_PACK] &
                         in_s[drive_seq_pkg::IN_COVER];
  assign chain_active = in_s[drive_seq_pkg::IN_PICK] &
                        in_s[drive_seq_pkg::IN_HOLD];
  assign start_press = start_s & ~start_prev;
  assign participating = remote_s & start_lamp;
  assign drop_req = ~start_lamp | ~sequence_power_ctl;
  assign speed_lost = heads_flying(state) & speed_ok_ctl & ~speed_s;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_prev <= 1'b0;
    end else begin
      start_prev <= start_s;
    end
  end
  // Start indicator: a press lights it only with interlocks made,
  // another press puts it out; an emergency also puts it out so a
  // hot motor is not restarted behind the operator's back.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_lamp <= 1'b0;
    end else if (speed_lost) begin
      start_lamp <= 1'b0;
    end else if (start_press) begin
      start_lamp <= ~start_lamp & interlocks_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sequence power and daisy chain
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sequence_power_ctl <= 1'b0;
    end else if (remote_s) begin
      sequence_power_ctl <= chain_active;
    end else begin
      sequence_power_ctl <= in_s[drive_seq_pkg::IN_AUX_OK];
    end
  end

  // Held back while this drive takes part (remote, start lit) and is not yet up to speed
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      seq_pick_out <= 1'b0;
      seq_hold_out <= 1'b0;
    end else if (participating && !speed_ok_ctl) begin
      seq_pick_out <= 1'b0;
      seq_hold_out <= 1'b0;
    end else begin
      seq_pick_out <= in_s[drive_seq_pkg::IN_PICK];
      seq_hold_out <= in_s[drive_seq_pkg::IN_HOLD];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Time base: one tick per millisecond, lamp flash from ticks
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_cnt <= '0;
      tick <= 1'b0;
    end else if (tick_cnt == KW'(TICK_CYCLES - 1)) begin
      tick_cnt <= '0;
      tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      flash_cnt <= '0;
      flash <= 1'b0;
    end else if (tick) begin
      if (flash_cnt == FW'(FLASH_TICKS - 1)) begin
        flash_cnt <= '0;
        flash <= ~flash;
      end else begin
        flash_cnt <= flash_cnt + 1'b1;
      end
    end
  end

  // Shared by load delay and braking; cleared on every state change
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      time_cnt <= '0;
    end else if (next_state != state) begin
      time_cnt <= '0;
    end else if (tick) begin
      time_cnt <= time_cnt + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Sequence state machine
  always_comb begin
    next_state = state;
    case (state)
      drive_seq_pkg::ST_IDLE: begin
        if (start_lamp && sequence_power_ctl && interlocks_ok) begin
          next_state = drive_seq_pkg::ST_SPINUP;
        end
      end
      drive_seq_pkg::ST_SPINUP: begin
        if (drop_req) begin
          next_state = drive_seq_pkg::ST_RTZ;
        end else if (speed_s) begin
          next_state = drive_seq_pkg::ST_DELAY;
        end
      end
      drive_seq_pkg::ST_DELAY: begin
        if (drop_req || speed_lost) begin
          next_state = drive_seq_pkg::ST_RTZ;
        end else if (tick && time_cnt == TW'(LOAD_TICKS - 1)) begin
          next_state = drive_seq_pkg::ST_LOAD;
        end
      end
      drive_seq_pkg::ST_LOAD: begin
        if (drop_req || speed_lost) begin
          next_state = drive_seq_pkg::ST_RTZ;
        end else if (in_s[drive_seq_pkg::IN_LOADED]) begin
          next_state = drive_seq_pkg::ST_READY;
        end
      end
      drive_seq_pkg::ST_READY: begin
        if (drop_req || speed_lost) begin
          next_state = drive_seq_pkg::ST_RTZ;
        end
      end
      drive_seq_pkg::ST_RTZ: begin
        if (in_s[drive_seq_pkg::IN_UNLOADED]) begin
          next_state = drive_seq_pkg::ST_BRAKE;
        end
      end
      drive_seq_pkg::ST_BRAKE: begin
        if (tick && time_cnt == TW'(BRAKE_TICKS - 1)) begin
          next_state = drive_seq_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = drive_seq_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= drive_seq_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Relay drivers, all de-energized under reset
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      start_ctl <= 1'b0;
      motor_power_ctl <= 1'b0;
    end else begin
      start_ctl <= spinning(next_state);
      motor_power_ctl <= spinning(next_state) ||
                         next_state == drive_seq_pkg::ST_RTZ;
    end
  end

  // Speed state drops with the sensor and is set only in spin-up; retract enable trails it by a cycle
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      speed_ok_ctl <= 1'b0;
      retract_enable_ctl <= 1'b0;
    end else begin
      if (!speed_s) begin
        speed_ok_ctl <= 1'b0;
      end else if (state == drive_seq_pkg::ST_SPINUP) begin
        speed_ok_ctl <= 1'b1;
      end
      retract_enable_ctl <= speed_ok_ctl;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      heads_load_go <= 1'b0;
      return_to_zero <= 1'b0;
    end else begin
      heads_load_go <= next_state == drive_seq_pkg::ST_LOAD;
      return_to_zero <= next_state == drive_seq_pkg::ST_RTZ;
    end
  end

  // Held until the heads are off the pack
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      emergency_retract <= 1'b0;
    end else if (speed_lost) begin
      emergency_retract <= 1'b1;
    end else if (state != drive_seq_pkg::ST_RTZ) begin
      emergency_retract <= 1'b0;
    end
  end

  // Brake apply is picked up by brake power, never on its own
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      brake_power_ctl <= 1'b0;
      brake_apply_ctl <= 1'b0;
    end else begin
      brake_power_ctl <= next_state == drive_seq_pkg::ST_BRAKE;
      brake_apply_ctl <= brake_power_ctl &&
                         next_state == drive_seq_pkg::ST_BRAKE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ready_lamp <= 1'b0;
      cover_lock <= 1'b0;
    end else begin
      cover_lock <= next_state != drive_seq_pkg::ST_IDLE;
      if (next_state == drive_seq_pkg::ST_READY) begin
        ready_lamp <= 1'b1;
      end else if (next_state == drive_seq_pkg::ST_IDLE) begin
        ready_lamp <= 1'b0;
      end else begin
        ready_lamp <= flash;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_unload_seen;
    state == drive_seq_pkg::ST_RTZ && in_s[drive_seq_pkg::IN_UNLOADED];
  endsequence
  sequence s_braking;
    !return_to_zero && !motor_power_ctl && brake_power_ctl
      ##1 brake_apply_ctl;
  endsequence
  a_local_seq_power:
    assert property (!remote_s && in_s[drive_seq_pkg::IN_AUX_OK]
                     |=> sequence_power_ctl)
    else $error("local sequence power not energized");
  a_remote_seq_power:
    assert property (remote_s && !chain_active |=> !sequence_power_ctl)
    else $error("remote sequence power without chain signals");
  a_chain_held:
    assert property (participating && !speed_ok_ctl |=> !seq_pick_out)
    else $error("chain passed before spindle up to speed");
  a_chain_passed:
    assert property (!participating
                     |=> seq_hold_out == $past(in_s[drive_seq_pkg::IN_HOLD]))
    else $error("chain not passed by idle drive");
  a_start_interlock:
    assert property ($rose(start_lamp) |-> $past(interlocks_ok))
    else $error("start lit with interlock open");
  a_motor_with_start:
    assert property (start_ctl |-> motor_power_ctl)
    else $error("start energized without motor control");
  a_drop_to_rtz:
    assert property (spinning(state) && drop_req
                     |=> !start_ctl && return_to_zero)
    else $error("power-off did not begin");
  a_unload_brake:
    assert property (s_unload_seen |=> s_braking)
    else $error("braking did not follow heads unloaded");
  a_retract_trails:
    assert property ($fell(speed_ok_ctl) |=> !retract_enable_ctl)
    else $error("retract enable held after speed loss");
  a_brake_end:
    assert property ($fell(brake_power_ctl) |-> !ready_lamp && !cover_lock
                     ##1 !brake_apply_ctl)
    else $error("braking end left lamp, lock or brake on");
  a_emergency:
    assert property (speed_lost |=> emergency_retract && return_to_zero)
    else $error("no emergency retract on speed loss");
endmodule : drive_power_sequencer
`default_nettype wire

/* test/seq_controller_model.sv */
// Partner model: disk controller driving the paired sequence lines.
// Assumes the bench commands it on clk; lines are driven levels.
`timescale 1ns/100ps
`default_nettype none
module seq_controller_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic slow,
  output logic pick,
  output logic hold
);
  // Slow mode: hold trails pick by a cycle, like a sluggish controller
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pick <= 1'b0;
      hold <= 1'b0;
    end else begin
      pick <= go;
      hold <= slow ? pick : go;
    end
  end
endmodule : seq_controller_model
`default_nettype wire

/* test/tb_top.sv */
// Self-checking bench for the drive power sequencer.
// Assumes scaled timer parameters; switches and sensors driven here.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e, m) begin checks_done++; if ((a) !== (e)) begin \
  miscompares++; $display("wrong value at %0t: %s", $time, m); end end
module tb_top;
  localparam int TC = 4;
  localparam int LT = 5;
  localparam int BT = 8;
  localparam int P_PICK = 0, P_HOLD = 1, P_SEQ = 2, P_START = 3;
  localparam int P_LAMP = 4, P_MOTOR = 5, P_SPEED = 6, P_RET = 7;
  localparam int P_LOAD = 8, P_RTZ = 9, P_EMER = 10, P_BPWR = 11;
  localparam int P_BAPP = 12, P_READY = 13, P_LOCK = 14;
  logic clk, rst_b, remote_mode, start_switch, main_breaker, aux_breaker;
  logic dc_breakers_ok, aux_supply_ok, pack_present, cover_closed;
  logic speed_ok, heads_loaded, heads_unloaded, go, slow;
  wire logic seq_pick_in, seq_hold_in;
  wire logic [14:0] outs;
  int miscompares = 0;
  int checks_done = 0;
  seq_controller_model ctl (.clk(clk), .rst_b(rst_b), .go(go),
    .slow(slow), .pick(seq_pick_in), .hold(seq_hold_in));
  drive_power_sequencer #(.TICK_CYCLES(TC), .LOAD_TICKS(LT),
    .BRAKE_TICKS(BT), .FLASH_TICKS(2)) dut (
    .clk(clk), .rst_b(rst_b), .remote_mode(remote_mode),
    .start_switch(start_switch), .main_breaker(main_breaker),
    .aux_breaker(aux_breaker), .dc_breakers_ok(dc_breakers_ok),
    .aux_supply_ok(aux_supply_ok), .seq_pick_in(seq_pick_in),
    .seq_hold_in(seq_hold_in), .pack_present(pack_present),
    .cover_closed(cover_closed), .speed_ok(speed_ok),
    .heads_loaded(heads_loaded), .heads_unloaded(heads_unloaded),
    .seq_pick_out(outs[0]), .seq_hold_out(outs[1]),
    .sequence_power_ctl(outs[2]), .start_ctl(outs[3]),
    .start_lamp(outs[4]), .motor_power_ctl(outs[5]),
    .speed_ok_ctl(outs[6]), .retract_enable_ctl(outs[7]),
    .heads_load_go(outs[8]), .return_to_zero(outs[9]),
    .emergency_retract(outs[10]), .brake_power_ctl(outs[11]),
    .brake_apply_ctl(outs[12]), .ready_lamp(outs[13]),
    .cover_lock(outs[14]));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_bit(input int i, input logic v, input int lim,
                          input string m);
    int k;
    k = 0;
    while (outs[i] !== v && k < lim) begin
      @(negedge clk);
      k++;
    end
    `CHK(outs[i], v, m)
    if (outs[i] !== v) summarize();
  endtask : wait_bit
  // Held long enough to pass the three-stage synchroniser
  task automatic press();
    @(posedge clk) start_switch <= 1'b1;
    cyc(8);
    @(posedge clk) start_switch <= 1'b0;
    cyc(8);
  endtask : press
  task automatic power_on(input logic rem);
    wait_bit(P_START, 1'b1, 10, "start");
    `CHK(outs[P_MOTOR], 1'b1, "motor")
    `CHK(outs[P_LOCK], 1'b1, "lock")
    wait_bit(P_READY, 1'b0, 20, "flash lo");
    wait_bit(P_READY, 1'b1, 20, "flash hi");
    if (rem) `CHK(outs[1:0], 2'b00, "chain held")
    @(posedge clk) speed_ok <= 1'b1;
    wait_bit(P_SPEED, 1'b1, 8, "speed");
    `CHK(outs[P_RET], 1'b0, "ret early")
    cyc(1);
    `CHK(outs[P_RET], 1'b1, "ret")
    if (rem) wait_bit(P_HOLD, 1'b1, 4, "chain on");
    cyc((LT - 1) * TC - 2);
    `CHK(outs[P_LOAD], 1'b0, "load early")
    wait_bit(P_LOAD, 1'b1, 2 * TC + 4, "load");
    @(posedge clk) begin
      heads_unloaded <= 1'b0;
      heads_loaded <= 1'b1;
    end
    cyc(8);
    repeat (20) begin
      cyc(1);
      `CHK(outs[P_READY], 1'b1, "steady")
    end
  endtask : power_on
  task automatic brake(input logic spin);
    @(posedge clk) begin
      heads_loaded <= 1'b0;
      heads_unloaded <= 1'b1;
    end
    wait_bit(P_BPWR, 1'b1, 10, "brake pwr");
    `CHK(outs[P_RTZ], 1'b0, "rtz off")
    `CHK(outs[P_MOTOR], 1'b0, "motor off")
    `CHK(outs[P_BAPP], 1'b0, "apply early")
    cyc(1);
    `CHK(outs[P_BAPP], 1'b1, "apply")
    if (spin) begin
      @(posedge clk) speed_ok <= 1'b0;
      wait_bit(P_SPEED, 1'b0, 8, "speed drop");
      `CHK(outs[P_RET], 1'b1, "ret order")
      cyc(1);
      `CHK(outs[P_RET], 1'b0, "ret drop")
    end
    wait_bit(P_BPWR, 1'b0, BT * TC + 8, "brake end");
    `CHK(outs[P_READY], 1'b0, "ready off")
    `CHK(outs[P_LOCK], 1'b0, "unlock")
    cyc(1);
    `CHK(outs[P_BAPP], 1'b0, "apply end")
    `CHK(outs[P_EMER], 1'b0, "emer clear")
  endtask : brake
  ////////////////////////////////////////////////////////////////////////
  task automatic t_local();
    @(posedge clk) aux_supply_ok <= 1'b0;
    wait_bit(P_SEQ, 1'b0, 8, "seq off");
    @(posedge clk) aux_supply_ok <= 1'b1;
    wait_bit(P_SEQ, 1'b1, 8, "seq on");
    // Each interlock opened alone must refuse the press
    for (int i = 0; i < 5; i++) begin
      @(posedge clk) {dc_breakers_ok, aux_breaker, main_breaker,
        pack_present, cover_closed} <= ~(5'h01 << i);
      press();
      `CHK(outs[P_LAMP], 1'b0, "refused")
      `CHK(outs[P_START], 1'b0, "no start")
    end
    @(posedge clk) {dc_breakers_ok, aux_breaker, main_breaker,
      pack_present, cover_closed} <= 5'h1f;
    press();
    power_on(1'b0);
    press();
    `CHK(outs[P_RTZ], 1'b1, "rtz")
    `CHK(outs[P_START], 1'b0, "start drop")
    wait_bit(P_READY, 1'b0, 20, "flash off");
    brake(1'b1);
    $display("test local done");
  endtask : t_local
  task automatic t_chain();
    for (int r = 0; r < 2; r++) begin
      @(posedge clk) begin
        remote_mode <= r[0];
        slow <= r[0];
        go <= 1'b1;
      end
      wait_bit(P_HOLD, 1'b1, 10, "pass on");
      `CHK(outs[P_PICK], 1'b1, "pass pick")
      `CHK(outs[P_START], 1'b0, "no join")
      @(posedge clk) go <= 1'b0;
      wait_bit(P_HOLD, 1'b0, 10, "pass off");
    end
    $display("test chain done");
  endtask : t_chain
  task automatic t_remote();
    press();
    cyc(10);
    `CHK(outs[P_START], 1'b0, "wait ctl")
    `CHK(outs[P_SEQ], 1'b0, "seq remote")
    @(posedge clk) go <= 1'b1;
    wait_bit(P_SEQ, 1'b1, 10, "seq pick");
    power_on(1'b1);
    @(posedge clk) go <= 1'b0;
    wait_bit(P_RTZ, 1'b1, 10, "ctl drop");
    `CHK(outs[P_START], 1'b0, "start drop")
    brake(1'b1);
    press();
    `CHK(outs[P_LAMP], 1'b0, "lamp clear")
    $display("test remote done");
  endtask : t_remote
  task automatic t_emer();
    @(posedge clk) remote_mode <= 1'b0;
    cyc(8);
    press();
    power_on(1'b0);
    @(posedge clk) speed_ok <= 1'b0;
    wait_bit(P_EMER, 1'b1, 8, "emergency");
    `CHK(outs[P_RTZ], 1'b1, "emer rtz")
    cyc(1);
    `CHK(outs[P_LAMP], 1'b0, "no restart")
    brake(1'b0);
    $display("test emergency done");
  endtask : t_emer
  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    remote_mode = 1'b0;
    start_switch = 1'b0;
    main_breaker = 1'b1;
    aux_breaker = 1'b1;
    dc_breakers_ok = 1'b1;
    aux_supply_ok = 1'b1;
    pack_present = 1'b1;
    cover_closed = 1'b1;
    speed_ok = 1'b0;
    heads_loaded = 1'b0;
    heads_unloaded = 1'b1;
    go = 1'b0;
    slow = 1'b0;
    cyc(12);
    `CHK(outs, 15'h0000, "reset")
    @(posedge clk) rst_b <= 1'b1;
    cyc(1);
    `CHK(outs, 15'h0000, "after reset")
    cyc(8);
    $display("test reset done");
    t_local();
    t_chain();
    t_remote();
    t_emer();
    summarize();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire
